// ===== rtl/tscp_pkg.sv
// Constants, types and field layout of the tuner serial control port
package tscp_pkg;
   localparam int REG_AW = 5;
   localparam int BYTE_W = 8;
   localparam int REG_COUNT = 32;
   localparam logic [REG_AW-1:0] REG_CHARGE_PUMP_CONTROL = 5'h00;
   localparam logic [REG_AW-1:0] REG_SYNTH_DIVIDER_LOW = 5'h01;
   localparam logic [REG_AW-1:0] REG_SYNTH_DIVIDER_HIGH = 5'h02;
   localparam logic [REG_AW-1:0] REG_TUNING_OFFSET_ONE = 5'h03;
   localparam logic [REG_AW-1:0] REG_TUNING_OFFSET_TWO = 5'h04;
   localparam logic [REG_AW-1:0] REG_FREQ_COUNTER_CTRL_A = 5'h05;
   localparam logic [REG_AW-1:0] REG_FREQ_COUNTER_CTRL_B = 5'h06;
   localparam logic [REG_AW-1:0] REG_UNUSED_SLOT_A = 5'h07;
   localparam logic [REG_AW-1:0] REG_SELECTIVITY_FILTER_CTRL = 5'h08;
   localparam logic [REG_AW-1:0] REG_ADJACENT_CHANNEL_CTRL = 5'h09;
   localparam logic [REG_AW-1:0] REG_MULTIPATH_CTRL = 5'h0a;
   localparam logic [REG_AW-1:0] REG_DEVIATION_CTRL = 5'h0b;
   localparam logic [REG_AW-1:0] REG_SOFT_MUTE_CTRL_A = 5'h0c;
   localparam logic [REG_AW-1:0] REG_SOFT_MUTE_CTRL_B = 5'h0d;
   localparam logic [REG_AW-1:0] REG_OSCILLATOR_REFERENCE_CTRL = 5'h0e;
   localparam logic [REG_AW-1:0] REG_GAIN_CONTROL_SETTINGS = 5'h0f;
   localparam logic [REG_AW-1:0] REG_UNUSED_SLOT_B = 5'h10;
   localparam logic [REG_AW-1:0] REG_DEMODULATOR_ADJUST = 5'h11;
   localparam logic [REG_AW-1:0] REG_LEVEL_METER_CTRL = 5'h12;
   localparam logic [REG_AW-1:0] REG_IF_GAIN_CRYSTAL_ADJUST = 5'h13;
   localparam logic [REG_AW-1:0] REG_TANK_ADJUST = 5'h14;
   localparam logic [REG_AW-1:0] REG_QUADRATURE_ADJUST = 5'h15;
   localparam logic [REG_AW-1:0] REG_TEST_CONTROL_A = 5'h16;
   localparam logic [REG_AW-1:0] REG_TEST_CONTROL_B = 5'h17;
   localparam logic [REG_AW-1:0] REG_TEST_CONTROL_C = 5'h18;
   localparam logic [REG_AW-1:0] REG_TEST_CONTROL_D = 5'h19;
   localparam logic [BYTE_W-1:0] REG_RESET = 8'h00;
   // Target address byte fields
   localparam int ADDR_DIR_BIT = 0;
   localparam int ADDR_STRAP_BIT = 1;
   localparam int ADDR_TYPE_LSB = 2;
   // Subaddress byte fields
   localparam int SUB_PAGE_BIT = 5;
   // Status byte fields
   localparam int STAT_NARROW_FILTER_ON = 0;
   localparam int STAT_NARROW_MID_SELECT = 1;
   localparam int STAT_MULTIPATH_FLAG = 2;
   localparam int STAT_PLL_LOCKED = 3;
   localparam int STAT_BELOW_MUTE = 4;
   localparam int STAT_ADJACENT = 5;
   localparam int STAT_STRONG_OVERDEV = 6;
   localparam int STAT_OVERDEV = 7;
   // Bits per byte before the acknowledge slot
   localparam logic [3:0] BIT_CNT_FULL = 4'h8;
   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_WAIT} tscp_state_t;
   typedef enum logic [1:0] {K_ADDR, K_SUB, K_DATA} tscp_kind_t;
endpackage : tscp_pkg

// ===== rtl/tscp_mem_if.sv
// Carrier between the protocol engine and the register memory
`timescale 1ns/10ps
interface tscp_mem_if;
   logic wr_en;
   logic [tscp_pkg::REG_AW-1:0] wr_addr;
   logic [tscp_pkg::BYTE_W-1:0] wr_data;
   logic [tscp_pkg::REG_AW-1:0] rd_addr;
   logic [tscp_pkg::BYTE_W-1:0] rd_data;
   modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : tscp_mem_if

// ===== rtl/tscp_sync.sv
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/10ps
module tscp_sync import tscp_pkg::*; #(
   parameter int W = 1,
   // Value held in reset; idle-high lines must not look like an edge when reset ends
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Data
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   always_comb begin
      next_meta = d_in;
      next_q = meta;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= RST_VAL;
         q_out <= RST_VAL;
      end else begin
         meta <= next_meta;
         q_out <= next_q;
      end
   end
endmodule : tscp_sync

// ===== rtl/tscp_regmem.sv
// Bank of 32 byte-wide control registers with registered read port
`timescale 1ns/10ps
module tscp_regmem import tscp_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Access
   tscp_mem_if.mem mb
);
   logic [BYTE_W-1:0] mem [REG_COUNT];
   logic [BYTE_W-1:0] next_mem [REG_COUNT];
   logic [BYTE_W-1:0] next_rd;

   always_comb begin
      next_mem = mem;
      if (mb.wr_en) begin
         next_mem[mb.wr_addr] = mb.wr_data;
      end
      next_rd = mem[mb.rd_addr];
   end

   // Reset keeps the analog controls at a known state before the first write
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < REG_COUNT; i++) begin
            mem[i] <= REG_RESET;
         end
         mb.rd_data <= REG_RESET;
      end else begin
         mem <= next_mem;
         mb.rd_data <= next_rd;
      end
   end
endmodule : tscp_regmem

// ===== rtl/tscp_serial_port.sv
// Two-wire serial target: start/stop, address match, register writes, status read
`timescale 1ns/10ps
module tscp_serial_port import tscp_pkg::*; #(
   // Device type code; value is arbitrary
   parameter logic [5:0] DEV_TYPE_ID = 6'h2a
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Serial bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Address strap pin
   input wire logic addr_strap,
   // Tuner status flags
   input wire logic narrow_filter_on,
   input wire logic narrow_mid_select,
   input wire logic multipath_flag,
   input wire logic pll_locked,
   input wire logic below_mute,
   input wire logic adjacent_flag,
   input wire logic strong_overdev,
   input wire logic overdev,
   // Register bank access for the tuner
   input wire logic [REG_AW-1:0] cfg_rd_addr,
   output logic [BYTE_W-1:0] cfg_rd_data,
   output logic cfg_wr_strobe,
   output logic [REG_AW-1:0] cfg_wr_addr,
   output logic [BYTE_W-1:0] cfg_wr_data
);
   localparam int SYNC_W = 11;
   // Clock and data idle high, so their synchroniser flops start high like the edge registers
   localparam logic [SYNC_W-1:0] SYNC_IDLE = 11'h003;

   tscp_mem_if mb ();

   logic [SYNC_W-1:0] sync_q;
   logic scl_s;
   logic sda_s;
   logic strap_s;
   logic [BYTE_W-1:0] stat;
   logic scl_d;
   logic sda_d;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic byte_done;
   logic addr_match;

   tscp_state_t state;
   tscp_state_t next_state;
   tscp_kind_t kind;
   tscp_kind_t next_kind;
   logic [BYTE_W-1:0] shreg;
   logic [BYTE_W-1:0] next_shreg;
   logic [BYTE_W-1:0] txb;
   logic [BYTE_W-1:0] next_txb;
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic [REG_AW-1:0] ptr;
   logic [REG_AW-1:0] next_ptr;
   logic page;
   logic next_page;
   logic is_read;
   logic next_is_read;
   logic next_oe;
   logic next_wr_en;
   logic [REG_AW-1:0] next_wr_addr;
   logic [BYTE_W-1:0] next_wr_data;

   // Pins and flags come from outside the clock domain
   tscp_sync #(.W(SYNC_W), .RST_VAL(SYNC_IDLE)) u_sync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .d_in({overdev, strong_overdev, adjacent_flag, below_mute, pll_locked,
             multipath_flag, narrow_mid_select, narrow_filter_on, addr_strap, sda_in, scl_in}),
      .q_out(sync_q)
   );

   tscp_regmem u_mem (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .mb(mb.mem)
   );

   assign scl_s = sync_q[0];
   assign sda_s = sync_q[1];
   assign strap_s = sync_q[2];
   assign mb.wr_en = cfg_wr_strobe;
   assign mb.wr_addr = cfg_wr_addr;
   assign mb.wr_data = cfg_wr_data;
   assign mb.rd_addr = cfg_rd_addr;
   assign cfg_rd_data = mb.rd_data;

   always_comb begin
      stat = '0;
      stat[STAT_NARROW_FILTER_ON] = sync_q[3];
      stat[STAT_NARROW_MID_SELECT] = sync_q[4];
      stat[STAT_MULTIPATH_FLAG] = sync_q[5];
      stat[STAT_PLL_LOCKED] = sync_q[6];
      stat[STAT_BELOW_MUTE] = sync_q[7];
      stat[STAT_ADJACENT] = sync_q[8];
      stat[STAT_STRONG_OVERDEV] = sync_q[9];
      stat[STAT_OVERDEV] = sync_q[10];
   end

   // Bus events; data moving while clock is high is never a bit
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;
   assign byte_done = (state == ST_RX) && scl_fall && (cnt == BIT_CNT_FULL) && !start_cond && !stop_cond;
   assign addr_match = (shreg[BYTE_W-1:ADDR_TYPE_LSB] == DEV_TYPE_ID)
                       && (shreg[ADDR_STRAP_BIT] == strap_s);

   always_comb begin
      next_state = state;
      next_kind = kind;
      next_shreg = shreg;
      next_txb = txb;
      next_cnt = cnt;
      next_ptr = ptr;
      next_page = page;
      next_is_read = is_read;
      next_oe = sda_oe;
      next_wr_en = 1'b0;
      next_wr_addr = cfg_wr_addr;
      next_wr_data = cfg_wr_data;
      if (stop_cond) begin
         next_state = ST_IDLE;
         next_oe = 1'b0;
      end else if (start_cond) begin
         // A repeated start restarts addressing from any state
         next_state = ST_RX;
         next_kind = K_ADDR;
         next_cnt = '0;
         next_oe = 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               next_oe = 1'b0;
            end
            ST_RX: begin
               if (scl_rise) begin
                  next_shreg = {shreg[BYTE_W-2:0], sda_s};
                  next_cnt = cnt + 4'h1;
               end else if (byte_done) begin
                  next_cnt = '0;
                  case (kind)
                     K_ADDR: begin
                        if (addr_match) begin
                           next_is_read = shreg[ADDR_DIR_BIT];
                           next_oe = 1'b1;
                           next_state = ST_ACK;
                        end else begin
                           next_state = ST_WAIT;
                        end
                     end
                     K_SUB: begin
                        next_ptr = shreg[REG_AW-1:0];
                        next_page = shreg[SUB_PAGE_BIT];
                        next_oe = 1'b1;
                        next_state = ST_ACK;
                     end
                     default: begin
                        next_wr_en = 1'b1;
                        next_wr_addr = ptr;
                        next_wr_data = shreg;
                        next_ptr = page ? ptr + 5'h01 : ptr;
                        next_oe = 1'b1;
                        next_state = ST_ACK;
                     end
                  endcase
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  if (kind == K_ADDR && is_read) begin
                     // Status is sampled once per byte so all eight bits agree
                     next_txb = stat;
                     next_oe = ~stat[BYTE_W-1];
                     next_cnt = 4'h1;
                     next_state = ST_TX;
                  end else begin
                     next_oe = 1'b0;
                     next_cnt = '0;
                     next_kind = (kind == K_ADDR) ? K_SUB : K_DATA;
                     next_state = ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (cnt == BIT_CNT_FULL) begin
                     next_oe = 1'b0;
                     next_state = ST_MACK;
                  end else begin
                     next_txb = {txb[BYTE_W-2:0], 1'b0};
                     next_oe = ~txb[BYTE_W-2];
                     next_cnt = cnt + 4'h1;
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  // Master acknowledge asks for another status byte
                  next_state = sda_s ? ST_WAIT : ST_ACK;
               end
            end
            ST_WAIT: begin
               next_oe = 1'b0;
            end
            default: begin
               next_state = ST_IDLE;
               next_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         state <= ST_IDLE;
         kind <= K_ADDR;
         shreg <= '0;
         txb <= '0;
         cnt <= '0;
         ptr <= '0;
         page <= 1'b0;
         is_read <= 1'b0;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
         cfg_wr_strobe <= 1'b0;
         cfg_wr_addr <= '0;
         cfg_wr_data <= '0;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
         state <= next_state;
         kind <= next_kind;
         shreg <= next_shreg;
         txb <= next_txb;
         cnt <= next_cnt;
         ptr <= next_ptr;
         page <= next_page;
         is_read <= next_is_read;
         sda_out <= 1'b0;
         sda_oe <= next_oe;
         cfg_wr_strobe <= next_wr_en;
         cfg_wr_addr <= next_wr_addr;
         cfg_wr_data <= next_wr_data;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   property p_start_arms;
      start_cond && !stop_cond |=> state == ST_RX && kind == K_ADDR && cnt == 4'h0;
   endproperty
   a_start_arms: assert property (p_start_arms) else $error("start not taken");

   property p_idle_quiet;
      state == ST_IDLE && !start_cond |=> !sda_oe && state == ST_IDLE;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("idle bus answered");

   property p_stop_idle;
      stop_cond |=> state == ST_IDLE && !sda_oe;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle");

   property p_sample_rise;
      state == ST_RX && scl_rise && !start_cond && !stop_cond |=> shreg[0] == $past(sda_s) && cnt == $past(cnt) + 4'h1;
   endproperty
   a_sample_rise: assert property (p_sample_rise) else $error("bit not sampled on rise");

   property p_addr_ack;
      byte_done && kind == K_ADDR |=> sda_oe == $past(addr_match) ##1 sda_oe == $past(sda_oe);
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");

   property p_sub_ptr;
      byte_done && kind == K_SUB |=> ptr == $past(shreg[REG_AW-1:0]) && page == $past(shreg[SUB_PAGE_BIT]) && sda_oe;
   endproperty
   a_sub_ptr: assert property (p_sub_ptr) else $error("subaddress not captured");

   property p_data_write;
      byte_done && kind == K_DATA |=> cfg_wr_strobe && cfg_wr_addr == $past(ptr) && cfg_wr_data == $past(shreg)
         ##1 !cfg_wr_strobe;
   endproperty
   a_data_write: assert property (p_data_write) else $error("data byte not stored");

   property p_page_step;
      byte_done && kind == K_DATA |=> ptr == $past(ptr) + {4'h0, $past(page)};
   endproperty
   a_page_step: assert property (p_page_step) else $error("pointer step wrong");

   property p_status_first;
      state == ST_ACK && kind == K_ADDR && is_read && scl_fall && !start_cond && !stop_cond
         |=> sda_oe == !$past(stat[STAT_OVERDEV]) && state == ST_TX;
   endproperty
   a_status_first: assert property (p_status_first) else $error("status msb wrong");

   property p_tx_release;
      state == ST_TX && scl_fall && cnt == BIT_CNT_FULL && !stop_cond && !start_cond |=> !sda_oe && state == ST_MACK;
   endproperty
   a_tx_release: assert property (p_tx_release) else $error("line not released");

   property p_drive_low_clock;
      $rose(sda_oe) |-> !scl_s;
   endproperty
   a_drive_low_clock: assert property (p_drive_low_clock) else $error("drive began with clock high");

   property p_ack_release;
      state == ST_ACK && scl_fall && !(kind == K_ADDR && is_read) && !start_cond && !stop_cond
         |=> !sda_oe && state == ST_RX && cnt == 4'h0;
   endproperty
   a_ack_release: assert property (p_ack_release) else $error("ack not released");

   property p_tx_bit;
      state == ST_TX && scl_fall && cnt != BIT_CNT_FULL && !start_cond && !stop_cond
         |=> sda_oe == !$past(txb[BYTE_W-2]) && state == ST_TX;
   endproperty
   a_tx_bit: assert property (p_tx_bit) else $error("status bit wrong");

   property p_master_nack;
      state == ST_MACK && scl_rise && sda_s |=> state == ST_WAIT && !sda_oe;
   endproperty
   a_master_nack: assert property (p_master_nack) else $error("nack not honoured");

   property p_master_ack;
      state == ST_MACK && scl_rise && !sda_s |=> state == ST_ACK && !sda_oe;
   endproperty
   a_master_ack: assert property (p_master_ack) else $error("ack not honoured");

   property p_mismatch_quiet;
      byte_done && kind == K_ADDR && !addr_match |=> state == ST_WAIT && !sda_oe;
   endproperty
   a_mismatch_quiet: assert property (p_mismatch_quiet) else $error("foreign address answered");

   property p_wait_quiet;
      state == ST_WAIT && !start_cond && !stop_cond |=> state == ST_WAIT && !sda_oe;
   endproperty
   a_wait_quiet: assert property (p_wait_quiet) else $error("waiting port drove the line");

   property p_strobe_source;
      cfg_wr_strobe |-> $past(byte_done) && $past(kind) == K_DATA;
   endproperty
   a_strobe_source: assert property (p_strobe_source) else $error("stray register write");

   c_write: cover property (byte_done && kind == K_DATA);
   c_read: cover property (state == ST_TX ##1 state == ST_MACK);
   c_mismatch: cover property (byte_done && kind == K_ADDR && !addr_match);
   c_restart: cover property (state == ST_RX && kind == K_DATA && start_cond);
endmodule : tscp_serial_port

// ===== tb/tscp_master.sv
// Two-wire bus master model driving the clock and pulling the data line
`timescale 1ns/10ps
module tscp_master (
   // Clock
   input wire logic core_clk,
   // Bus lines
   input wire logic sda_w,
   output logic scl,
   output logic sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   // Long low phase gives the device time to drop its acknowledge first
   task bitx(input logic b, output logic s);
      scl = 1'b0;
      tick(2);
      sda_low = ~b;
      tick(3);
      scl = 1'b1;
      tick(3);
      s = sda_w;
   endtask : bitx
   task start;
      tick(4);
      sda_low = 1'b1;
      tick(4);
   endtask : start
   task stop;
      scl = 1'b0;
      tick(2);
      sda_low = 1'b1;
      tick(3);
      scl = 1'b1;
      tick(4);
      sda_low = 1'b0;
      tick(4);
   endtask : stop
   task wbyte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bitx(d[i], s);
      bitx(1'b1, s);
      ack = ~s;
   endtask : wbyte
   task rbyte(input logic mack, output logic [7:0] d);
      logic s;
      for (int i = 0; i < 8; i++) begin
         bitx(1'b1, s);
         d = {d[6:0], s};
      end
      bitx(~mack, s);
   endtask : rbyte
endmodule : tscp_master

// ===== tb/tb_tscp_serial_port.sv
// Self-checking bench of the tuner serial control port
`timescale 1ns/10ps
module tb_tscp_serial_port import tscp_pkg::*; ;
   localparam logic [5:0] TID = 6'h15; // Arbitrary type code
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic addr_strap = 1'b0;
   logic [7:0] stat = 8'h00;
   logic [REG_AW-1:0] cfg_rd_addr = '0;
   logic [BYTE_W-1:0] cfg_rd_data;
   logic [BYTE_W-1:0] cfg_wr_data;
   logic [REG_AW-1:0] cfg_wr_addr;
   logic cfg_wr_strobe, sda_out, sda_oe, scl, sda_low, sda_w, ack_b, bit_b;
   logic [7:0] exp_mem [32];
   int err_total = 0;
   int num_checks = 0;
   int seed = 80;
   int strobes = 0;
   int exp_strobes = 0;
   always #50 core_clk = ~core_clk;
   // Open drain with pull-up
   assign sda_w = ~sda_low & ~(sda_oe & ~sda_out);
   always @(posedge core_clk) if (cfg_wr_strobe === 1'b1) strobes <= strobes + 1;
   tscp_serial_port #(.DEV_TYPE_ID(TID)) tscp_serial_port_i (
      .core_clk(core_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
      .sda_oe(sda_oe), .addr_strap(addr_strap), .narrow_filter_on(stat[0]), .narrow_mid_select(stat[1]),
      .multipath_flag(stat[2]), .pll_locked(stat[3]), .below_mute(stat[4]), .adjacent_flag(stat[5]),
      .strong_overdev(stat[6]), .overdev(stat[7]), .cfg_rd_addr(cfg_rd_addr), .cfg_rd_data(cfg_rd_data),
      .cfg_wr_strobe(cfg_wr_strobe), .cfg_wr_addr(cfg_wr_addr), .cfg_wr_data(cfg_wr_data)
   );
   tscp_master tscp_master_i (.core_clk(core_clk), .sda_w(sda_w), .scl(scl), .sda_low(sda_low));
   task tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   function automatic logic ab_ok(input logic [7:0] ab);
      return ab[7:1] == {TID, addr_strap};
   endfunction : ab_ok
   function automatic logic [4:0] next_ptr(input logic [4:0] p, input logic page);
      return page ? p + 5'h01 : p;
   endfunction : next_ptr
   task chk_mem;
      for (int i = 0; i < 32; i++) begin
         cfg_rd_addr = 5'(i);
         tick(2);
         chk("reg", exp_mem[i], cfg_rd_data);
      end
      chk("strobes", 8'(exp_strobes), 8'(strobes));
   endtask : chk_mem
   task wr(input logic [7:0] ab, input logic [7:0] sub, input int n);
      logic a;
      logic ok;
      logic [4:0] p;
      logic [7:0] d;
      logic [4:0] lp;
      ok = ab_ok(ab);
      p = sub[4:0];
      tscp_master_i.start();
      tscp_master_i.wbyte(ab, a);
      chk("addr ack", {7'h0, ok}, {7'h0, a});
      tscp_master_i.wbyte(sub, a);
      chk("sub ack", {7'h0, ok}, {7'h0, a});
      for (int i = 0; i < n; i++) begin
         d = 8'($random(seed));
         tscp_master_i.wbyte(d, a);
         chk("data ack", {7'h0, ok}, {7'h0, a});
         if (ok) begin
            exp_mem[p] = d;
            lp = p;
            exp_strobes++;
            p = next_ptr(p, sub[SUB_PAGE_BIT]);
         end
      end
      tscp_master_i.stop();
      if (ok && n > 0) chk("wr data", d, cfg_wr_data);
      if (ok && n > 0) chk("wr addr", {3'h0, lp}, {3'h0, cfg_wr_addr});
   endtask : wr
   task rd(input logic [7:0] ab);
      logic a;
      logic [7:0] d;
      stat = 8'($random(seed));
      tick(4);
      tscp_master_i.start();
      tscp_master_i.wbyte(ab, a);
      chk("rd ack", 8'h01, {7'h0, a});
      tscp_master_i.rbyte(1'b1, d);
      chk("status", stat, d);
      tscp_master_i.rbyte(1'b0, d);
      chk("status again", stat, d);
      tscp_master_i.stop();
   endtask : rd
   task tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   initial begin
      #3000000;
      err_total++;
      tally_and_finish();
   end
   initial begin
      for (int i = 0; i < 32; i++) exp_mem[i] = 8'h00;
      repeat (2) @(posedge core_clk);
      #1;
      rst_b = 1'b1;
      tick(4);
      chk_mem();
      $display("test reset done");
      for (int s = 0; s < 2; s++) begin
         addr_strap = s[0];
         tick(4);
         // Page mode from slot 30 wraps to 0
         wr({TID, s[0], 1'b0}, 8'h3e, 4);
         wr({TID, ~s[0], 1'b0}, 8'h25, 2);
         wr({~TID, s[0], 1'b0}, 8'h25, 2);
         rd({TID, s[0], 1'b1});
         chk_mem();
      end
      $display("test address done");
      // Reserved slot, page off: one register rewritten
      wr({TID, addr_strap, 1'b0}, 8'h07, 3);
      chk_mem();
      $display("test page off done");
      // Bytes clocked without a start are ignored
      tscp_master_i.wbyte({TID, addr_strap, 1'b0}, ack_b);
      chk("no start ack", 8'h00, {7'h0, ack_b});
      tscp_master_i.wbyte(8'h23, ack_b);
      tscp_master_i.wbyte(8'h5a, ack_b);
      tscp_master_i.stop();
      chk_mem();
      $display("test no start done");
      // Stop inside a data byte drops the partial byte
      tscp_master_i.start();
      tscp_master_i.wbyte({TID, addr_strap, 1'b0}, ack_b);
      tscp_master_i.wbyte(8'h23, ack_b);
      for (int i = 0; i < 4; i++) tscp_master_i.bitx(1'b1, bit_b);
      tscp_master_i.stop();
      chk_mem();
      $display("test stop abort done");
      // Repeated start inside a data byte drops it and opens a new write
      tscp_master_i.start();
      tscp_master_i.wbyte({TID, addr_strap, 1'b0}, ack_b);
      tscp_master_i.wbyte(8'h29, ack_b);
      chk("restart sub ack", 8'h01, {7'h0, ack_b});
      for (int i = 0; i < 3; i++) tscp_master_i.bitx(1'b1, bit_b);
      wr({TID, addr_strap, 1'b0}, 8'h2c, 2);
      chk_mem();
      $display("test restart done");
      for (int k = 0; k < 8; k++) begin
         wr({TID, addr_strap, 1'b0}, 8'($random(seed)) & 8'h3f, $random(seed) & 7);
         rd({TID, addr_strap, 1'b1});
      end
      chk_mem();
      $display("test random done");
      tally_and_finish();
   end
endmodule : tb_tscp_serial_port
